// >>> bsc_pkg.sv
// package: opcodes, flag positions and carriers for the branch unit
package bsc_pkg;

    // ----------------------------------------------------------------
    // flag register bit positions
    // ----------------------------------------------------------------
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // ----------------------------------------------------------------
    // constants and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] ALL_ONES = 8'h_ff;
    localparam logic [7:0] ZERO_BYTE = 8'h_00;
    localparam logic [15:0] PC_RESET = 16'h_0000;
    localparam logic [15:0] SP_RESET = 16'h_00df;
    localparam logic [1:0] CYC_JUMP = 2'd2;
    localparam logic [1:0] CYC_CALL = 2'd3;
    localparam logic [1:0] CYC_TAKEN = 2'd2;
    localparam logic [1:0] STALL_IDLE = 2'd0;
    localparam logic [15:0] PC_ONE = 16'h_0001;
    localparam logic [15:0] PC_TWO = 16'h_0002;
    localparam logic [15:0] PC_THREE = 16'h_0003;

    // ----------------------------------------------------------------
    // operations handled here (already decoded upstream)
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_NONE, OP_CLRBITS, OP_INC, OP_DEC, OP_TEST, OP_CLRREG,
        OP_SETREG, OP_RJUMP, OP_IJUMP, OP_RCALL, OP_ICALL,
        OP_CPSKIP, OP_CMP, OP_CMPC, OP_CMPI, OP_SKBR_CLR, OP_SKBR_SET,
        OP_SKBIO_CLR, OP_SKBIO_SET, OP_BR_SET, OP_BR_CLR
    } op_e;

    // one instruction as presented by the fetch/decode stage
    typedef struct packed {
        op_e op;
        logic [7:0] dst;       // destination register value
        logic [7:0] src;       // source_register value or io value
        logic [7:0] imm;       // constant or mask
        logic [11:0] offset;   // signed word displacement
        logic [2:0] bitsel;    // bit or flag index
        logic next_two_word;   // instruction to skip is two words
    } instr_s;

    // results back to the register file and stack
    typedef struct packed {
        logic wr_en;
        logic [7:0] wr_data;
        logic push_en;
        logic [15:0] push_addr;
        logic [15:0] push_data;
    } result_s;

endpackage

// >>> branch_skip_compare_unit.sv
// branch, skip, compare and single-operand register unit
//
// Notes on behaviour
// - clear bits ands with inverted mask, flags ZNV
// - increment/decrement by one, flags ZNVS only
// - test ands register with itself, flags ZNV
// - clear register xors to zero, flags ZNV
// - set register loads all ones, flags kept
// - relative jump pc+offset+1, two cycles
// - indirect jump loads pc from z, two cycles
// - calls take three cycles, no flags
// - compare-skip-equal advances pc two or three
// - compares discard difference, update ZNVCH flags
// - skip on register bit condition
// - skip on io register bit condition
// - branch on any chosen flag bit
// - equal/not-equal on z, carry branches on c
// - same-or-higher branches when carry clear
// - ge when n^v clear, plus when n clear
// - lt when n^v set, minus when n set
// - half carry branches test h flag
// - t flag branches test t flag
// - overflow branches test v flag
`timescale 1ns/10ps
module branch_skip_compare_unit
    import bsc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // instruction from decode
    input wire logic issue_in,
    input wire instr_s instr_in,
    input wire logic [15:0] z_pointer_in,
    // flag register write-back
    output logic [7:0] flag_register_out,
    // register file, stack and pc
    output result_s result_out,
    output logic [15:0] pc_out,
    output logic [15:0] sp_out,
    output logic busy_out
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] flags_r, flags_nxt;
    logic [15:0] pc_r, pc_nxt;
    logic [15:0] sp_r, sp_nxt;
    logic [1:0] stall_r, stall_nxt;
    result_s res_r, res_nxt;

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    wire accept = issue_in && (stall_r == 2'd0);
    wire op_e op = instr_in.op;
    wire [7:0] rd = instr_in.dst;
    wire [7:0] source_register = instr_in.src;
    // sign-extended word displacement
    wire [15:0] disp = {{4{instr_in.offset[11]}}, instr_in.offset};
    wire [15:0] pc_seq = pc_r + PC_ONE;
    wire [15:0] pc_rel = pc_r + disp + PC_ONE;
    // skip length follows the width of the skipped instruction
    wire [15:0] pc_skip = pc_r + (instr_in.next_two_word ?
                                   PC_THREE : PC_TWO);
    wire sel_flag = flags_r[instr_in.bitsel];
    wire sel_bit = source_register[instr_in.bitsel];

    // ----------------------------------------------------------------
    // call bookkeeping: one word slot, stack grows downward
    // ----------------------------------------------------------------
    // the push pairs with sp dropping by two on the same edge
    wire [15:0] push_slot = sp_r - PC_ONE;
    wire [15:0] sp_after_call = sp_r - PC_TWO;

    // ----------------------------------------------------------------
    // single-operand results
    // ----------------------------------------------------------------
    wire [7:0] clrbits_res = rd & (ALL_ONES - instr_in.imm);
    wire [7:0] inc_res = rd + 8'h_01;
    wire [7:0] dec_res = rd - 8'h_01;
    wire [7:0] test_res = rd & rd;
    wire [7:0] clr_res = rd ^ rd;
    wire inc_ovf = (rd == 8'h_7f);
    wire dec_ovf = (rd == 8'h_80);

    // ----------------------------------------------------------------
    // compare: rd - rr (- c) or rd - k, difference discarded
    // ----------------------------------------------------------------
    wire [7:0] cmp_rhs = (op == OP_CMPI) ? instr_in.imm : source_register;
    wire cmp_cin = (op == OP_CMPC) ? flags_r[FLAG_C] : 1'b0;
    wire [8:0] cmp_diff = {1'b0, rd} - {1'b0, cmp_rhs} - {8'h_00, cmp_cin};
    wire [4:0] cmp_lo = {1'b0, rd[3:0]} - {1'b0, cmp_rhs[3:0]} -
                        {4'h_0, cmp_cin};
    wire [7:0] cmp_res = cmp_diff[7:0];
    wire cmp_v = (rd[7] & ~cmp_rhs[7] & ~cmp_res[7]) |
                 (~rd[7] & cmp_rhs[7] & cmp_res[7]);
    // carry-compare keeps z only if result zero, else clears it
    wire cmp_z = (op == OP_CMPC) ? ((cmp_res == ZERO_BYTE) &
                 flags_r[FLAG_Z]) : (cmp_res == ZERO_BYTE);

    // ----------------------------------------------------------------
    // conditions for skips and branches
    // ----------------------------------------------------------------
    // conditions read the flags as they stood before this op
    wire skip_cond =
        (op == OP_CPSKIP) ? (rd == source_register) :
        (op == OP_SKBR_CLR) ? ~sel_bit :
        (op == OP_SKBR_SET) ? sel_bit :
        (op == OP_SKBIO_CLR) ? ~sel_bit :
        (op == OP_SKBIO_SET) ? sel_bit : 1'b0;
    // named branches (eq/ne, cs/cc, sh/lo, mi/pl, ge/lt, hs/hc, ts/tc,
    // vs/vc) arrive as br_set/br_clr on the matching flag index, so
    // one path covers them: lt/ge use the s flag = n ^ v
    wire br_cond =
        (op == OP_BR_SET) ? sel_flag :
        (op == OP_BR_CLR) ? ~sel_flag : 1'b0;

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    function automatic logic [7:0] znv(input logic [7:0] f,
                                       input logic [7:0] r,
                                       input logic v);
        logic [7:0] t;
        t = f;
        t[FLAG_Z] = (r == ZERO_BYTE);
        t[FLAG_N] = r[7];
        t[FLAG_V] = v;
        t[FLAG_S] = r[7] ^ v;
        znv = t;
    endfunction

    always_comb begin
        flags_nxt = flags_r;
        pc_nxt = pc_r;
        sp_nxt = sp_r;
        stall_nxt = (stall_r != 2'd0) ? stall_r - 2'd1 : 2'd0;
        res_nxt = '0;
        // a busy unit only counts down; issues are refused
        if (accept) begin
            pc_nxt = pc_seq;
            unique case (op)
                OP_NONE: begin
                    // nothing for this unit: the pc simply steps
                    pc_nxt = pc_seq;
                end
                OP_CLRBITS: begin
                    res_nxt.wr_en = 1'b1;
                    res_nxt.wr_data = clrbits_res;
                    flags_nxt = znv(flags_r, clrbits_res, 1'b0);
                end
                OP_INC: begin
                    res_nxt.wr_en = 1'b1;
                    res_nxt.wr_data = inc_res;
                    flags_nxt = znv(flags_r, inc_res, inc_ovf);
                end
                OP_DEC: begin
                    res_nxt.wr_en = 1'b1;
                    res_nxt.wr_data = dec_res;
                    flags_nxt = znv(flags_r, dec_res, dec_ovf);
                end
                OP_TEST: begin
                    res_nxt.wr_en = 1'b1;
                    res_nxt.wr_data = test_res;
                    flags_nxt = znv(flags_r, test_res, 1'b0);
                end
                OP_CLRREG: begin
                    res_nxt.wr_en = 1'b1;
                    res_nxt.wr_data = clr_res;
                    flags_nxt = znv(flags_r, clr_res, 1'b0);
                end
                OP_SETREG: begin
                    res_nxt.wr_en = 1'b1;
                    res_nxt.wr_data = ALL_ONES;
                end
                OP_RJUMP: begin
                    pc_nxt = pc_rel;
                    stall_nxt = CYC_JUMP - 2'd1;
                end
                OP_IJUMP: begin
                    pc_nxt = z_pointer_in;
                    stall_nxt = CYC_JUMP - 2'd1;
                end
                OP_RCALL: begin
                    pc_nxt = pc_rel;
                    stall_nxt = CYC_CALL - 2'd1;
                    // return address pushed on the same edge that control moves
                    res_nxt.push_en = 1'b1;
                    res_nxt.push_addr = push_slot;
                    res_nxt.push_data = pc_seq;
                    sp_nxt = sp_after_call;
                end
                OP_ICALL: begin
                    pc_nxt = z_pointer_in;
                    stall_nxt = CYC_CALL - 2'd1;
                    res_nxt.push_en = 1'b1;
                    res_nxt.push_addr = push_slot;
                    res_nxt.push_data = pc_seq;
                    sp_nxt = sp_after_call;
                end
                OP_CMP, OP_CMPC, OP_CMPI: begin
                    flags_nxt[FLAG_Z] = cmp_z;
                    flags_nxt[FLAG_N] = cmp_res[7];
                    flags_nxt[FLAG_V] = cmp_v;
                    flags_nxt[FLAG_S] = cmp_res[7] ^ cmp_v;
                    flags_nxt[FLAG_C] = cmp_diff[8];
                    flags_nxt[FLAG_H] = cmp_lo[4];
                end
                OP_CPSKIP: begin
                    if (skip_cond) begin
                        pc_nxt = pc_skip;
                        stall_nxt = CYC_TAKEN - 2'd1;
                    end
                end
                OP_SKBR_CLR, OP_SKBR_SET: begin
                    if (skip_cond) begin
                        pc_nxt = pc_skip;
                        stall_nxt = CYC_TAKEN - 2'd1;
                    end
                end
                OP_SKBIO_CLR, OP_SKBIO_SET: begin
                    if (skip_cond) begin
                        pc_nxt = pc_skip;
                        stall_nxt = CYC_TAKEN - 2'd1;
                    end
                end
                OP_BR_SET, OP_BR_CLR: begin
                    if (br_cond) begin
                        pc_nxt = pc_rel;
                        stall_nxt = CYC_TAKEN - 2'd1;
                    end
                end
                default: begin
                    // spare codes come from a broken decode: step only
                    pc_nxt = pc_seq;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // flags change only when an accepted op updates them
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            flags_r <= ZERO_BYTE;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // pc steps on every accepted op, so it is never left stale
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pc_r <= PC_RESET;
        end else begin
            pc_r <= pc_nxt;
        end
    end

    // stack pointer moves only on calls
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sp_r <= SP_RESET;
        end else begin
            sp_r <= sp_nxt;
        end
    end

    // stall holds off issue for the extra cycles of a transfer
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            stall_r <= STALL_IDLE;
        end else begin
            stall_r <= stall_nxt;
        end
    end

    // result is a one-cycle pulse for the register file and stack
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            res_r <= '0;
        end else begin
            res_r <= res_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // busy is combinational so issue can be held off the same cycle
    assign busy_out = (stall_r != 2'd0);
    assign flag_register_out = flags_r;
    assign result_out = res_r;
    assign pc_out = pc_r;
    assign sp_out = sp_r;

endmodule

// >>> bsc_props.sv
// assertions for the branch, skip and compare unit
`timescale 1ns/10ps
module bsc_props
    import bsc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // watched ports
    input wire logic issue_in,
    input wire instr_s instr_in,
    input wire logic [15:0] z_pointer_in,
    input wire logic [7:0] flag_register_out,
    input wire result_s result_out,
    input wire logic [15:0] pc_out,
    input wire logic [15:0] sp_out,
    input wire logic busy_out
);
    // ----
    // helpers
    // ----
    wire acc = issue_in && !busy_out;
    wire is_call = instr_in.op == OP_RCALL || instr_in.op == OP_ICALL;
    // offset is a signed word count, widened before the add
    wire [15:0] rel = {{4{instr_in.offset[11]}}, instr_in.offset};
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // ----
    // properties
    // ----
    rjump_pc_a: assert property (acc && instr_in.op == OP_RJUMP |=>
        busy_out && pc_out == $past(pc_out) + $past(rel) + PC_ONE
        ##1 !busy_out) else $error("relative jump wrong");
    ijump_pc_a: assert property (acc && instr_in.op == OP_IJUMP |=>
        pc_out == $past(z_pointer_in) && $stable(flag_register_out))
        else $error("indirect jump wrong");
    call_busy_a: assert property (acc && is_call |=>
        busy_out [*2] ##1 !busy_out) else $error("call length wrong");
    call_push_a: assert property (acc && is_call |=>
        result_out.push_en && sp_out == $past(sp_out) - PC_TWO)
        else $error("call push wrong");
    inc_value_a: assert property (acc && instr_in.op == OP_INC |=>
        result_out.wr_en && result_out.wr_data == $past(instr_in.dst) + 8'h_01)
        else $error("increment wrong");
    set_reg_a: assert property (acc && instr_in.op == OP_SETREG |=>
        result_out.wr_data == ALL_ONES && $stable(flag_register_out))
        else $error("set register wrong");
    clr_reg_a: assert property (acc && instr_in.op == OP_CLRREG |=>
        result_out.wr_data == ZERO_BYTE && flag_register_out[FLAG_Z])
        else $error("clear register wrong");
    clr_bits_a: assert property (acc && instr_in.op == OP_CLRBITS |=>
        result_out.wr_data == ($past(instr_in.dst) & ~$past(instr_in.imm)))
        else $error("clear bits wrong");
    br_taken_a: assert property (acc && instr_in.op == OP_BR_SET &&
        flag_register_out[instr_in.bitsel] |=> busy_out &&
        pc_out == $past(pc_out) + $past(rel) + PC_ONE)
        else $error("taken branch wrong");
    cmp_discard_a: assert property (acc && instr_in.op == OP_CMP |=>
        !result_out.wr_en && flag_register_out[FLAG_Z] ==
        ($past(instr_in.dst) == $past(instr_in.src)))
        else $error("compare wrong");
    skip_none_a: assert property (acc && instr_in.op == OP_CPSKIP &&
        instr_in.dst != instr_in.src |=> !busy_out &&
        pc_out == $past(pc_out) + PC_ONE) else $error("no-skip wrong");
endmodule

bind branch_skip_compare_unit bsc_props i_bsc_props (
    .clk_in(clk_in), .rst_in(rst_in), .issue_in(issue_in),
    .instr_in(instr_in), .z_pointer_in(z_pointer_in),
    .flag_register_out(flag_register_out), .result_out(result_out),
    .pc_out(pc_out), .sp_out(sp_out), .busy_out(busy_out));

// >>> tb.sv
// self-checking testbench for the branch, skip and compare unit
`timescale 1ns/10ps
module tb;
    import bsc_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic issue_in = 1'b0;
    instr_s instr_in = '0;
    logic [15:0] z_pointer_in = 16'h_0000;
    logic [7:0] flag_register_out;
    result_s result_out;
    logic [15:0] pc_out;
    logic [15:0] sp_out;
    logic busy_out;
    int err_total = 0;
    int n_tests = 0;
    int ncyc;
    logic [15:0] epc;
    result_s res_seen;
    branch_skip_compare_unit i_branch_skip_compare_unit (
        .clk_in(clk_in), .rst_in(rst_in), .issue_in(issue_in),
        .instr_in(instr_in), .z_pointer_in(z_pointer_in),
        .flag_register_out(flag_register_out), .result_out(result_out),
        .pc_out(pc_out), .sp_out(sp_out), .busy_out(busy_out));
    initial begin
        forever #4 clk_in = ~clk_in;
    end
    // ----
    // compares and drivers
    // ----
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t byte %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t word %h want %h", $time, got, exp);
        end
    endtask
    // one request, then wait out busy; src doubles as the constant
    task automatic fire(input op_e op, input logic [7:0] d,
        input logic [7:0] s, input logic [11:0] k, input logic [2:0] b,
        input logic tw);
        @(posedge clk_in);
        #1;
        issue_in = 1'b1;
        instr_in = '{op, d, s, s, k, b, tw};
        @(posedge clk_in);
        #1;
        issue_in = 1'b0;
        res_seen = result_out;
        ncyc = 0;
        while (busy_out !== 1'b0 && ncyc < 8) begin
            @(posedge clk_in);
            #1;
            ncyc++;
        end
    endtask
    // flow step: pc advance and extra cycles only when control moves
    task automatic step(input op_e op, input logic [7:0] d,
        input logic [7:0] s, input logic [2:0] b, input logic tw,
        input logic [15:0] adv);
        fire(op, d, s, 12'h_004, b, tw);
        epc = epc + adv;
        chk_word(pc_out, epc);
        chk_word(16'(ncyc), (adv == PC_ONE) ? 16'h_0000 : 16'h_0001);
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_alu;
        fire(OP_CLRBITS, 8'h_f0, 8'h_30, 12'h_000, 3'd0, 1'b0);
        chk_byte(result_out.wr_data, 8'h_c0);
        chk_byte(flag_register_out & 8'h_0e, 8'h_04);
        fire(OP_INC, 8'h_7f, 8'h_00, 12'h_000, 3'd0, 1'b0);
        chk_byte(flag_register_out & 8'h_0e, 8'h_0c);
        fire(OP_DEC, 8'h_80, 8'h_00, 12'h_000, 3'd0, 1'b0);
        chk_byte(result_out.wr_data, 8'h_7f);
        chk_byte(flag_register_out & 8'h_0e, 8'h_08);
        fire(OP_TEST, 8'h_80, 8'h_00, 12'h_000, 3'd0, 1'b0);
        chk_byte(flag_register_out & 8'h_0e, 8'h_04);
        fire(OP_CLRREG, 8'h_55, 8'h_00, 12'h_000, 3'd0, 1'b0);
        chk_byte(result_out.wr_data, ZERO_BYTE);
        chk_byte(flag_register_out & 8'h_0e, 8'h_02);
        fire(OP_SETREG, 8'h_12, 8'h_00, 12'h_000, 3'd0, 1'b0);
        chk_byte(result_out.wr_data, ALL_ONES);
        chk_byte(flag_register_out & 8'h_0e, 8'h_02);
    endtask
    task automatic t_cmp;
        fire(OP_CMP, 8'h_03, 8'h_05, 12'h_000, 3'd0, 1'b0);
        chk_byte(flag_register_out & 8'h_3f, 8'h_35);
        chk_byte({7'h_00, result_out.wr_en}, 8'h_00);
        fire(OP_CMPC, 8'h_05, 8'h_04, 12'h_000, 3'd0, 1'b0);
        chk_byte(flag_register_out & 8'h_3f, 8'h_00);
        fire(OP_CMPI, 8'h_03, 8'h_03, 12'h_000, 3'd0, 1'b0);
        chk_byte(flag_register_out & 8'h_3f, 8'h_02);
    endtask
    task automatic t_jump_call;
        z_pointer_in = 16'h_0100;
        fire(OP_IJUMP, 8'h_00, 8'h_00, 12'h_000, 3'd0, 1'b0);
        chk_word(pc_out, 16'h_0100);
        chk_word(16'(ncyc), 16'h_0001);
        fire(OP_RJUMP, 8'h_00, 8'h_00, 12'h_ffe, 3'd0, 1'b0);
        chk_word(pc_out, 16'h_00ff);
        chk_word(16'(ncyc), 16'h_0001);
        fire(OP_RCALL, 8'h_00, 8'h_00, 12'h_005, 3'd0, 1'b0);
        chk_word(pc_out, 16'h_0105);
        chk_word(sp_out, SP_RESET - PC_TWO);
        chk_word(16'(ncyc), 16'h_0002);
        chk_byte({7'h_00, res_seen.push_en}, 8'h_01);
        chk_word(res_seen.push_data, 16'h_0100);
        chk_word(res_seen.push_addr, SP_RESET - PC_ONE);
        z_pointer_in = 16'h_0200;
        fire(OP_ICALL, 8'h_00, 8'h_00, 12'h_000, 3'd0, 1'b0);
        chk_word(pc_out, 16'h_0200);
        chk_word(sp_out, SP_RESET - 16'h_0004);
        chk_word(16'(ncyc), 16'h_0002);
        chk_word(res_seen.push_data, 16'h_0106);
        chk_word(res_seen.push_addr, SP_RESET - PC_THREE);
        chk_byte(flag_register_out, 8'h_02);
    endtask
    task automatic t_branch_skip;
        logic tk;
        logic [7:0] fl;
        fl = 8'h_35;
        fire(OP_CMP, 8'h_03, 8'h_05, 12'h_000, 3'd0, 1'b0);
        z_pointer_in = 16'h_0300;
        fire(OP_IJUMP, 8'h_00, 8'h_00, 12'h_000, 3'd0, 1'b0);
        epc = 16'h_0300;
        // flags now 35: c, n, s, h set; z, v, t, i clear
        for (int b = 0; b < 16; b++) begin
            tk = fl[b % 8] ^ (b >= 8);
            step(b < 8 ? OP_BR_SET : OP_BR_CLR, 8'h_00, 8'h_00, 3'(b), 1'b0,
                tk ? 16'h_0005 : PC_ONE);
            chk_byte(flag_register_out, 8'h_35);
        end
        step(OP_CPSKIP, 8'h_5a, 8'h_5a, 3'd0, 1'b0, PC_TWO);
        step(OP_CPSKIP, 8'h_5a, 8'h_5a, 3'd0, 1'b1, PC_THREE);
        step(OP_CPSKIP, 8'h_5a, 8'h_5b, 3'd0, 1'b0, PC_ONE);
        step(OP_SKBR_SET, 8'h_00, 8'h_04, 3'd2, 1'b0, PC_TWO);
        step(OP_SKBR_CLR, 8'h_00, 8'h_04, 3'd2, 1'b0, PC_ONE);
        step(OP_SKBIO_CLR, 8'h_00, 8'h_7f, 3'd7, 1'b1, PC_THREE);
        step(OP_SKBIO_SET, 8'h_00, 8'h_7f, 3'd7, 1'b0, PC_ONE);
        chk_byte(flag_register_out, 8'h_35);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // the whole run is about a hundred cycles; this bound is generous
    initial begin
        #40000;
        err_total++;
        results();
    end
    initial begin
        repeat (4) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        t_alu();
        t_cmp();
        t_jump_call();
        t_branch_skip();
        results();
    end
endmodule
